// File: design/scma_top.sv
// Connection/data memory access engine with mode register and fault counter.
// Assumes the matrix scans the connection memory on ref_clk and that data
// memory answers combinationally to dm_addr.
//
// Local design decision: the strobed register port.
`timescale 1ns/100ps
// Function
// - Writing destination byte launches one memory access with held mode bits.
// - Destination byte holds 5-bit output slot and 3-bit output mux.
// - Top two mux bits pick the even pin pair, for inputs too.
// - Input slot number is source slot bits with mux lsb appended.
// - Output slot number is destination slot bits with mux lsb appended.
// - Mux lsb selects even/odd mux at 2M, even/odd slot at 4M.
// - High clock bit sets 8M clock; sampling point follows rate.
// - Without cyclic modes destination is address, else tracks current address.
// - Memory select clear reads data memory only, writes ignored.
// - Memory select set: read loads data register, write stores it.
// - Bidirectional writes forward with loop and reverse without loop.
// - Cyclic write fills from destination to FF, bidirectional ignored.
// - Cyclic read loads next location after each data register read, up to FF.
// - Limited cyclic write fills selected mux up to slot 1F.
// - Limited cyclic read advances within mux up to slot 1F.
// - Transparent write uses destination as source, ignores bidirectional.
// - Transparent with cyclic modes makes identity connections from destination up to slot 1F or FF.
// - Reading the fault counter returns value then clears it.
// - Counter counts analyzer errors only when enabled and synchronised.
// - Counter saturates at maximum instead of wrapping.
// - Counter reaching FFFF sets the overflow flag.
// - Entry analyzer enable acts only during that entry's slot.
module scma_top
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata_r,
  output logic [7:0] dm_addr_r,
  input wire logic [15:0] dm_rdata,
  input wire logic [7:0] scan_addr,
  output logic [15:0] scan_entry_r,
  output logic prs_window_r,
  input wire logic prs_err,
  input wire logic prs_synced,
  output logic high_clock_select_r,
  output logic samp_half_4m_r,
  output logic [1:0] out_pin_pair_r,
  output logic [5:0] out_slot_num_r,
  output logic [1:0] in_pin_pair_r,
  output logic [5:0] in_slot_num_r,
  output logic busy_r,
  output logic fault_counter_overflow_flag_r
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  scma_pkg::scma_state_t state_r;
  logic [15:0] conn_mem [0:255];
  logic [5:0] mode_r;
  logic [7:0] destination_byte_r;
  logic [7:0] cur_r;
  logic [15:0] conn_mem_data_register_r;
  logic auto_rd_r;
  logic [15:0] fault_count;
  logic fault_hit_max;
  logic [15:0] rd_mux;
  logic [15:0] conn_wdata;
  logic [7:0] conn_waddr;
  logic conn_we;
  logic [15:0] conn_rd_word;
  logic m_read, m_bidir, m_cyc_full, m_memsel, m_cyc_lim, m_transp, m_cyc;
  logic fill_last, rd_last;
  logic mode_wr, fault_wr, fault_rd, data_wr, data_rd, cfg_wr, stat_rd;
  logic fault_inc;

  assign mode_wr = reg_wr && reg_addr == scma_pkg::ADDR_MODE_REG;
  assign fault_wr = reg_wr && reg_addr == scma_pkg::ADDR_FAULT;
  assign fault_rd = reg_rd && reg_addr == scma_pkg::ADDR_FAULT;
  assign data_wr = reg_wr && reg_addr == scma_pkg::ADDR_DATA;
  assign data_rd = reg_rd && reg_addr == scma_pkg::ADDR_DATA;
  assign cfg_wr = reg_wr && reg_addr == scma_pkg::ADDR_CFG;
  assign stat_rd = reg_rd && reg_addr == scma_pkg::ADDR_STAT;

  // Mode bits in upper byte, bit 11 is memory select
  assign m_read = mode_r[scma_pkg::MODE_READ - 8];
  assign m_bidir = mode_r[scma_pkg::MODE_BIDIR - 8];
  assign m_cyc_full = mode_r[scma_pkg::MODE_CYC - 8];
  assign m_memsel = mode_r[scma_pkg::MODE_MEMSEL - 8];
  assign m_cyc_lim = mode_r[scma_pkg::MODE_CYC_LIM - 8];
  assign m_transp = mode_r[scma_pkg::MODE_TRANSP - 8];
  assign m_cyc = m_cyc_full || m_cyc_lim;

  // ---------------------------------------------------------------
  // Connection memory write path
  // ---------------------------------------------------------------
  // Full cyclic wins over limited when both are set
  assign fill_last = m_cyc_full ? (cur_r == scma_pkg::MEM_LAST)
                   : (cur_r[4:0] == scma_pkg::SLOT_LAST);
  assign rd_last = fill_last;
  assign conn_rd_word = conn_mem[cur_r];

  always_comb
  begin
    conn_we = 1'b0;
    conn_waddr = cur_r;
    conn_wdata = conn_mem_data_register_r;
    if (state_r == scma_pkg::ST_FILL)
    begin
      conn_we = 1'b1;
      if (m_transp)
        conn_wdata = {conn_mem_data_register_r[15:8], cur_r};
    end
    else if (state_r == scma_pkg::ST_REV)
    begin
      conn_we = 1'b1;
      conn_waddr = conn_mem_data_register_r[7:0];
      conn_wdata = {conn_mem_data_register_r[15:8], destination_byte_r};
      conn_wdata[scma_pkg::ENT_LOOP] = 1'b0;
    end
  end

  // No reset on the array: software must program it before use
  always_ff @(posedge ref_clk)
  begin
    if (conn_we)
      conn_mem[conn_waddr] <= conn_wdata;
  end

  // ---------------------------------------------------------------
  // Access engine
  // ---------------------------------------------------------------
  // A mode write while busy is dropped whole, so a running fill is never torn
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      state_r <= scma_pkg::ST_IDLE;
      mode_r <= scma_pkg::MODE_REG_RST[13:8];
      destination_byte_r <= scma_pkg::MODE_REG_RST[7:0];
      cur_r <= scma_pkg::MODE_REG_RST[7:0];
      conn_mem_data_register_r <= 16'h0000;
      auto_rd_r <= 1'b0;
      dm_addr_r <= 8'h00;
    end
    else
    begin
      case (state_r)
        scma_pkg::ST_IDLE:
        begin
          if (mode_wr)
          begin
            mode_r <= reg_wdata[13:8];
            destination_byte_r <= reg_wdata[7:0];
            cur_r <= reg_wdata[7:0];
            auto_rd_r <= 1'b0;
            if (!reg_wdata[scma_pkg::MODE_MEMSEL])
            begin
              dm_addr_r <= reg_wdata[7:0];
              state_r <= scma_pkg::ST_DMRD;
            end
            else if (reg_wdata[scma_pkg::MODE_READ])
            begin
              auto_rd_r <= reg_wdata[scma_pkg::MODE_CYC] || reg_wdata[scma_pkg::MODE_CYC_LIM];
              state_r <= scma_pkg::ST_CMRD;
            end
            else
              state_r <= scma_pkg::ST_FILL;
          end
          else if (data_wr)
            conn_mem_data_register_r <= reg_wdata;
          else if (data_rd && auto_rd_r)
          begin
            if (rd_last)
              auto_rd_r <= 1'b0;
            else
            begin
              cur_r <= cur_r + 8'h01;
              state_r <= scma_pkg::ST_CMRD;
            end
          end
        end
        scma_pkg::ST_FILL:
        begin
          if (m_cyc && !fill_last)
            cur_r <= cur_r + 8'h01;
          else if (m_bidir && !m_cyc && !m_transp)
            state_r <= scma_pkg::ST_REV;
          else
            state_r <= scma_pkg::ST_IDLE;
        end
        scma_pkg::ST_REV:
          state_r <= scma_pkg::ST_IDLE;
        scma_pkg::ST_CMRD:
        begin
          conn_mem_data_register_r <= conn_rd_word;
          state_r <= scma_pkg::ST_IDLE;
        end
        scma_pkg::ST_DMRD:
        begin
          conn_mem_data_register_r <= dm_rdata;
          state_r <= scma_pkg::ST_IDLE;
        end
        default:
          state_r <= scma_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      busy_r <= 1'b0;
    else
      busy_r <= state_r != scma_pkg::ST_IDLE;
  end

  // ---------------------------------------------------------------
  // Slot decode, clock select and matrix scan
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      out_pin_pair_r <= 2'b00;
      out_slot_num_r <= 6'h00;
      in_pin_pair_r <= 2'b00;
      in_slot_num_r <= 6'h00;
    end
    else
    begin
      out_pin_pair_r <= destination_byte_r[7:6];
      in_pin_pair_r <= conn_mem_data_register_r[7:6];
      out_slot_num_r <= {destination_byte_r[4:0],
                         destination_byte_r[scma_pkg::MUX_LSB]};
      in_slot_num_r <= {conn_mem_data_register_r[4:0],
                        conn_mem_data_register_r[scma_pkg::MUX_LSB]};
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      high_clock_select_r <= 1'b0;
      samp_half_4m_r <= 1'b1;
    end
    else if (cfg_wr)
    begin
      high_clock_select_r <= reg_wdata[scma_pkg::CFG_HICLK];
      samp_half_4m_r <= !reg_wdata[scma_pkg::CFG_HICLK];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      scan_entry_r <= 16'h0000;
      prs_window_r <= 1'b0;
    end
    else
    begin
      scan_entry_r <= conn_mem[scan_addr];
      prs_window_r <= conn_mem[scan_addr][scma_pkg::ENT_PRS];
    end
  end

  // ---------------------------------------------------------------
  // Fault counter and overflow flag
  // ---------------------------------------------------------------
  assign fault_inc = prs_err && prs_synced && prs_window_r;

  scma_fault_ctr #(.W(16)) u_fault_ctr
  (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .inc(fault_inc),
    .clr(fault_rd),
    .ld(fault_wr),
    .ld_val(reg_wdata),
    .count(fault_count),
    .hit_max(fault_hit_max)
  );

  // Set wins over the clear by a status read
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      fault_counter_overflow_flag_r <= 1'b0;
    else if (fault_hit_max)
      fault_counter_overflow_flag_r <= 1'b1;
    else if (stat_rd)
      fault_counter_overflow_flag_r <= 1'b0;
  end

  // ---------------------------------------------------------------
  // Register read-back
  // ---------------------------------------------------------------
  always_comb
  begin
    rd_mux = 16'h0000;
    case (reg_addr)
      scma_pkg::ADDR_MODE_REG: rd_mux = {2'b00, mode_r, cur_r};
      scma_pkg::ADDR_FAULT: rd_mux = fault_count;
      scma_pkg::ADDR_DATA: rd_mux = conn_mem_data_register_r;
      scma_pkg::ADDR_CFG: rd_mux = {15'h0000, high_clock_select_r};
      scma_pkg::ADDR_STAT: rd_mux = {14'h0000, fault_counter_overflow_flag_r, busy_r};
      default: rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      reg_rdata_r <= 16'h0000;
    else if (reg_rd)
      reg_rdata_r <= rd_mux;
    else
      reg_rdata_r <= 16'h0000;
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_launch_conn_write: assert property (
    state_r == scma_pkg::ST_IDLE && mode_wr && reg_wdata[scma_pkg::MODE_MEMSEL]
      && !reg_wdata[scma_pkg::MODE_READ] |=> state_r == scma_pkg::ST_FILL)
    else $error("write to destination byte did not start a fill");
  a_dm_no_write: assert property (
    state_r == scma_pkg::ST_IDLE && mode_wr && !reg_wdata[scma_pkg::MODE_MEMSEL]
      |=> !conn_we ##1 conn_mem_data_register_r == $past(dm_rdata))
    else $error("data memory access wrote or loaded wrong word");
  a_conn_read_loads: assert property (
    state_r == scma_pkg::ST_CMRD |=> conn_mem_data_register_r == $past(conn_rd_word))
    else $error("connection memory read not loaded");
  a_rev_no_loop: assert property (
    state_r == scma_pkg::ST_REV |-> !conn_wdata[scma_pkg::ENT_LOOP]
      && conn_waddr == conn_mem_data_register_r[7:0] && $past(state_r) == scma_pkg::ST_FILL)
    else $error("reverse connection malformed");
  a_fill_stops_ff: assert property (
    state_r == scma_pkg::ST_FILL && m_cyc_full && cur_r == scma_pkg::MEM_LAST
      |=> state_r == scma_pkg::ST_IDLE)
    else $error("cyclic fill ran past last location");
  a_lim_in_mux: assert property (
    state_r == scma_pkg::ST_FILL && m_cyc_lim && !m_cyc_full
      |-> cur_r[7:5] == destination_byte_r[7:5])
    else $error("limited fill left its multiplex");
  a_transp_identity: assert property (
    state_r == scma_pkg::ST_FILL && m_transp |-> conn_wdata[7:0] == conn_waddr)
    else $error("transparent entry not identity");
  a_fault_clear: assert property (
    fault_rd && !fault_inc |=> fault_count == 16'h0000 && reg_rdata_r == $past(fault_count))
    else $error("fault counter read did not return and clear");
  a_fault_gate: assert property (
    !fault_inc && !fault_rd && !fault_wr |=> fault_count == $past(fault_count))
    else $error("fault counter moved without a gated error");
  a_ovf_flag: assert property (
    fault_hit_max |=> fault_counter_overflow_flag_r && fault_count == scma_pkg::FAULT_MAX)
    else $error("overflow flag not raised at maximum");

  c_full_fill: cover property (state_r == scma_pkg::ST_FILL && m_cyc_full && fill_last);
  c_bidir_rev: cover property (state_r == scma_pkg::ST_REV);
  c_cyc_read: cover property (data_rd && auto_rd_r ##1 state_r == scma_pkg::ST_CMRD);
  c_saturate: cover property (fault_inc && fault_count == scma_pkg::FAULT_MAX);
endmodule : scma_top

// File: design/scma_pkg.sv
// Constants for the connection-memory access block and its fault counter.
// Assumes a single 100 MHz ref_clk domain and a plain strobe register port.
package scma_pkg;
  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_MODE_REG = 8'h10;
  localparam logic [7:0] ADDR_FAULT = 8'h12;
  localparam logic [7:0] ADDR_DATA = 8'h40;
  localparam logic [7:0] ADDR_CFG = 8'h42;
  localparam logic [7:0] ADDR_STAT = 8'h44;
  // ---------------------------------------------------------------
  // Reset values and field positions
  // ---------------------------------------------------------------
  localparam logic [15:0] MODE_REG_RST = 16'h0800;
  localparam logic [15:0] FAULT_RST = 16'h0000;
  localparam int MODE_READ = 8;
  localparam int MODE_BIDIR = 9;
  localparam int MODE_CYC = 10;
  localparam int MODE_MEMSEL = 11;
  localparam int MODE_CYC_LIM = 12;
  localparam int MODE_TRANSP = 13;
  localparam int MUX_LSB = 5;
  localparam int ENT_LOOP = 8;
  localparam int ENT_PRS = 9;
  localparam int CFG_HICLK = 0;
  localparam int STAT_BUSY = 0;
  localparam int STAT_OVF = 1;
  localparam logic [7:0] MEM_LAST = 8'hff;
  localparam logic [4:0] SLOT_LAST = 5'h1f;
  localparam logic [15:0] FAULT_MAX = 16'hffff;
  // ---------------------------------------------------------------
  // Access engine states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_FILL = 3'b001,
    ST_REV = 3'b010,
    ST_CMRD = 3'b011,
    ST_DMRD = 3'b100
  } scma_state_t;
endpackage : scma_pkg

// File: design/scma_fault_ctr.sv
// Saturating sequence fault counter with load and clear-on-read.
// Assumes inc, clr and ld come from logic on the same clock.
`timescale 1ns/100ps
module scma_fault_ctr
#(
  parameter int W = 16
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic inc,
  input wire logic clr,
  input wire logic ld,
  input wire logic [W-1:0] ld_val,
  output logic [W-1:0] count,
  output logic hit_max
);
  localparam logic [W-1:0] MAXV = {W{1'b1}};
  localparam logic [W-1:0] ONE = {{(W-1){1'b0}}, 1'b1};

  initial
  begin
    if (W != 16)
      $error("fault counter width must be 16");
  end

  // Clear on read with a fault in the same cycle leaves the count at one
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      count <= scma_pkg::FAULT_RST;
    else if (ld)
      count <= ld_val;
    else if (clr)
      count <= inc ? ONE : scma_pkg::FAULT_RST;
    else if (inc && count != MAXV)
      count <= count + ONE;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      hit_max <= 1'b0;
    else
      hit_max <= inc && !ld && !clr && (count == MAXV - ONE);
  end
endmodule : scma_fault_ctr

// File: sim/scma_far_model.sv
// Far-side model: data memory and the sequence analyzer's error source.
// Assumes the same ref_clk as the access block and a memory that answers at once.
`timescale 1ns/100ps
module scma_far_model
(
  input wire logic ref_clk,
  input wire logic [7:0] dm_addr,
  output logic [15:0] dm_rdata,
  output logic prs_err
);
  // ---------------------------------------------------------------
  // Data memory
  // ---------------------------------------------------------------
  // Word carries its own address, so a stale address shows as a wrong word
  assign dm_rdata = {8'ha5, dm_addr};
  // ---------------------------------------------------------------
  // Analyzer errors
  // ---------------------------------------------------------------
  initial prs_err = 1'b0;
  // One-cycle pulses with a gap, as the analyzer reports them
  task automatic send_errors(input int n);
    repeat (n)
    begin
      @(posedge ref_clk);
      prs_err <= 1'b1;
      @(posedge ref_clk);
      prs_err <= 1'b0;
    end
  endtask : send_errors
endmodule : scma_far_model

// File: sim/scma_top_test.sv
// Self-checking bench for the connection-memory access block.
// Assumes the far-side model supplies data memory words and analyzer errors.
`timescale 1ns/100ps
`define SCMA_CHK(g, e) \
  begin \
    total_checks = total_checks + 1; \
    if ((g) !== (e)) \
    begin \
      failures = failures + 1; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); \
    end \
  end
module scma_top_test;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic ref_clk = 1'b0;
  logic rst_n;
  logic [7:0] reg_addr, dm_addr_r, scan_addr;
  logic [15:0] reg_wdata, reg_rdata_r, dm_rdata, scan_entry_r;
  logic reg_wr, reg_rd, prs_err, prs_synced, prs_window_r, busy_r;
  logic high_clock_select_r, samp_half_4m_r, fault_counter_overflow_flag_r;
  logic [1:0] out_pin_pair_r, in_pin_pair_r;
  logic [5:0] out_slot_num_r, in_slot_num_r;
  int failures = 0;
  int total_checks = 0;
  always #5 ref_clk = ~ref_clk;
  // ---------------------------------------------------------------
  // Instances
  // ---------------------------------------------------------------
  scma_top uut
  (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .dm_addr_r(dm_addr_r),
    .dm_rdata(dm_rdata), .scan_addr(scan_addr), .scan_entry_r(scan_entry_r),
    .prs_window_r(prs_window_r), .prs_err(prs_err), .prs_synced(prs_synced),
    .high_clock_select_r(high_clock_select_r), .samp_half_4m_r(samp_half_4m_r),
    .out_pin_pair_r(out_pin_pair_r), .out_slot_num_r(out_slot_num_r),
    .in_pin_pair_r(in_pin_pair_r), .in_slot_num_r(in_slot_num_r), .busy_r(busy_r),
    .fault_counter_overflow_flag_r(fault_counter_overflow_flag_r)
  );
  scma_far_model far
  (
    .ref_clk(ref_clk), .dm_addr(dm_addr_r), .dm_rdata(dm_rdata), .prs_err(prs_err)
  );
  // ---------------------------------------------------------------
  // Bus tasks
  // ---------------------------------------------------------------
  task automatic report_and_stop;
    if (failures == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    `SCMA_CHK(reg_rdata_r, e)
  endtask : rd_chk
  // Scan port leaves the address in place, so the analyzer window follows it
  task automatic chk_conn(input logic [7:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    scan_addr <= a;
    repeat (2) @(posedge ref_clk);
    #1;
    `SCMA_CHK(scan_entry_r, e)
  endtask : chk_conn
  task automatic settle;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask : settle
  // Mode writes are dropped while busy, so every access is waited out
  task automatic wait_idle;
    int n;
    n = 0;
    repeat (3) @(posedge ref_clk);
    while (busy_r !== 1'b0 && n < 400)
    begin
      @(posedge ref_clk);
      n = n + 1;
    end
    if (n >= 400)
    begin
      failures = failures + 1;
      report_and_stop();
    end
  endtask : wait_idle
  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial
  begin
    rst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    scan_addr = 8'h00;
    prs_synced = 1'b0;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd_chk(scma_pkg::ADDR_MODE_REG, 16'h0800);
    rd_chk(scma_pkg::ADDR_FAULT, 16'h0000);
    `SCMA_CHK(samp_half_4m_r, 1'b1)
    wr(scma_pkg::ADDR_CFG, 16'h0001);
    settle();
    `SCMA_CHK(high_clock_select_r, 1'b1)
    `SCMA_CHK(samp_half_4m_r, 1'b0)
    rd_chk(8'h20, 16'h0000);
    wr(scma_pkg::ADDR_DATA, 16'h00e3);
    settle();
    `SCMA_CHK(in_pin_pair_r, 2'h3)
    `SCMA_CHK(in_slot_num_r, 6'h07)
    wr(scma_pkg::ADDR_MODE_REG, 16'h0865);
    wait_idle();
    `SCMA_CHK(out_pin_pair_r, 2'h1)
    `SCMA_CHK(out_slot_num_r, 6'h0b)
    chk_conn(8'h65, 16'h00e3);
    wr(scma_pkg::ADDR_DATA, 16'h0000);
    wr(scma_pkg::ADDR_MODE_REG, 16'h0965);
    wait_idle();
    rd_chk(scma_pkg::ADDR_DATA, 16'h00e3);
    // Data memory mode with the read bit clear still reads and never writes
    wr(scma_pkg::ADDR_MODE_REG, 16'h0042);
    wait_idle();
    `SCMA_CHK(dm_addr_r, 8'h42)
    rd_chk(scma_pkg::ADDR_DATA, 16'ha542);
    chk_conn(8'h65, 16'h00e3);
    wr(scma_pkg::ADDR_DATA, 16'h0134);
    wr(scma_pkg::ADDR_MODE_REG, 16'h0a10);
    wait_idle();
    chk_conn(8'h10, 16'h0134);
    chk_conn(8'h34, 16'h0010);
    // Cyclic fill with the bidirectional bit set, and a mode write while busy
    wr(scma_pkg::ADDR_DATA, 16'h0077);
    wr(scma_pkg::ADDR_MODE_REG, 16'h0efc);
    wr(scma_pkg::ADDR_MODE_REG, 16'h0801);
    rd_chk(scma_pkg::ADDR_STAT, 16'h0001);
    `SCMA_CHK(busy_r, 1'b1)
    wait_idle();
    rd_chk(scma_pkg::ADDR_MODE_REG, 16'h0eff);
    wr(scma_pkg::ADDR_DATA, 16'h0200);
    wr(scma_pkg::ADDR_MODE_REG, 16'h2cfd);
    wait_idle();
    chk_conn(8'hfc, 16'h0077);
    chk_conn(8'hff, 16'h02ff);
    wr(scma_pkg::ADDR_MODE_REG, 16'h0dfe);
    wait_idle();
    rd_chk(scma_pkg::ADDR_DATA, 16'h02fe);
    wait_idle();
    rd_chk(scma_pkg::ADDR_DATA, 16'h02ff);
    wait_idle();
    rd_chk(scma_pkg::ADDR_MODE_REG, 16'h0dff);
    wr(scma_pkg::ADDR_DATA, 16'h1111);
    wr(scma_pkg::ADDR_MODE_REG, 16'h0860);
    wait_idle();
    wr(scma_pkg::ADDR_DATA, 16'h0200);
    wr(scma_pkg::ADDR_MODE_REG, 16'h385d);
    wait_idle();
    chk_conn(8'h60, 16'h1111);
    chk_conn(8'h5f, 16'h025f);
    wr(scma_pkg::ADDR_MODE_REG, 16'h195e);
    wait_idle();
    rd_chk(scma_pkg::ADDR_DATA, 16'h025e);
    wait_idle();
    rd_chk(scma_pkg::ADDR_DATA, 16'h025f);
    wait_idle();
    rd_chk(scma_pkg::ADDR_DATA, 16'h025f);
    chk_conn(8'h5d, 16'h025d);
    `SCMA_CHK(prs_window_r, 1'b1)
    // Errors count only when synchronised and inside an enabled slot
    far.send_errors(2);
    rd_chk(scma_pkg::ADDR_FAULT, 16'h0000);
    @(posedge ref_clk);
    prs_synced <= 1'b1;
    far.send_errors(3);
    rd_chk(scma_pkg::ADDR_FAULT, 16'h0003);
    rd_chk(scma_pkg::ADDR_FAULT, 16'h0000);
    chk_conn(8'h65, 16'h00e3);
    `SCMA_CHK(prs_window_r, 1'b0)
    far.send_errors(2);
    rd_chk(scma_pkg::ADDR_FAULT, 16'h0000);
    chk_conn(8'h5d, 16'h025d);
    wr(scma_pkg::ADDR_FAULT, 16'hff00);
    far.send_errors(1);
    rd_chk(scma_pkg::ADDR_FAULT, 16'hff01);
    wr(scma_pkg::ADDR_FAULT, 16'hfffe);
    far.send_errors(3);
    settle();
    `SCMA_CHK(fault_counter_overflow_flag_r, 1'b1)
    rd_chk(scma_pkg::ADDR_FAULT, 16'hffff);
    rd_chk(scma_pkg::ADDR_STAT, 16'h0002);
    settle();
    `SCMA_CHK(fault_counter_overflow_flag_r, 1'b0)
    report_and_stop();
  end
endmodule : scma_top_test
